// ### logic/cfc_pkg.sv
// Shared constants and types for the flash cache and P/E control
package cfc_pkg;
  // Geometry of the flash space and the read cache
  localparam int AW = 20;
  localparam int CACHE_BYTES = 256;
  localparam int LINE_BYTES = 16;
  localparam int WAYS = 8;
  localparam int SETS = CACHE_BYTES / (LINE_BYTES * WAYS);
  localparam int NLINES = SETS * WAYS;
  localparam int SIX = (SETS > 1) ? $clog2(SETS) : 1;
  localparam int WW = $clog2(WAYS);
  localparam int TW = AW - 4 - SIX;
  localparam int BLK_SHIFT = 15;
  localparam int BW = AW - BLK_SHIFT;
  localparam int PGM_BYTES = 128;
  localparam int PGM_WORDS = PGM_BYTES / 4;
  // Core clock and the miss cost it implies
  localparam int CLK_MHZ = 100;
  localparam int MISS_LO_MHZ = 50;
  localparam int MISS_HI_MHZ = 100;
  localparam int MISS_CYC = (CLK_MHZ > MISS_HI_MHZ) ? 3 : (CLK_MHZ > MISS_LO_MHZ) ? 2 : 1;
  localparam logic [1:0] MISS_CNT = 2'(MISS_CYC);
  // Data values
  localparam logic [127:0] ERASED_LINE = {4{32'hFFFFFFFF}};
  localparam logic [BW-1:0] TM_BLK_A = 5'h08;
  localparam logic [BW-1:0] TM_BLK_B = 5'h09;
  // Register byte offsets
  localparam logic [7:0] OFF_STAT = 8'h00;
  localparam logic [7:0] OFF_IEN = 8'h04;
  localparam logic [7:0] OFF_ENTRY = 8'h08;
  localparam logic [7:0] OFF_SUSP = 8'h0C;
  localparam logic [7:0] OFF_CEN = 8'h10;
  localparam logic [7:0] OFF_CIV = 8'h14;
  localparam logic [7:0] OFF_SUA = 8'h18;
  localparam logic [7:0] OFF_TM = 8'h1C;
  localparam logic [7:0] OFF_PST = 8'h20;
  localparam logic [7:0] OFF_SADDR = 8'h24;
  localparam logic [7:0] OFF_UID0 = 8'h30;
  localparam logic [7:0] OFF_UID1 = 8'h34;
  localparam logic [7:0] OFF_UID2 = 8'h38;
  localparam logic [7:0] OFF_UID3 = 8'h3C;
  localparam logic [7:0] OFF_CMD = 8'h40;
  // Field positions and reset values
  localparam int ST_DONE_BIT = 0;
  localparam int ST_CODE_ACCESS_VIOLATION_FLAG_BIT = 7;
  localparam int ENTRY_BIT = 0;
  localparam int KEY_LSB = 8;
  localparam logic [7:0] RST_STAT = 8'h00;
  localparam logic [7:0] RST_IEN = 8'h00;
  // Sequencer command codes
  localparam logic [7:0] CMD_PROGRAM = 8'h01;
  localparam logic [7:0] CMD_ERASE = 8'h02;
  localparam logic [7:0] CMD_SUSPEND = 8'h03;
  localparam logic [7:0] CMD_RESUME = 8'h04;

  typedef enum logic [1:0] {PE_IDLE, PE_DATA, PE_RUN, PE_SUSP} cfc_pe_state_type;
  typedef enum logic {RD_IDLE, RD_FILL} cfc_rd_state_type;
  typedef enum logic {OP_PROGRAM, OP_ERASE} cfc_op_type;

  // Command bus towards the flash array
  typedef struct packed {
    logic start;
    logic suspend;
    logic resume;
    cfc_op_type op;
    logic [AW-1:0] addr;
    logic wr;
    logic [31:0] wdata;
  } cfc_fl_cmd_type;
endpackage

// ### logic/cfc_lru.sv
// Least recently used way tracker for one cache set
`timescale 1ns/10ps
module cfc_lru #(
  parameter int WAYS = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic touch_i,
  input wire logic [$clog2(WAYS)-1:0] way_i,
  output logic [$clog2(WAYS)-1:0] victim_o
);
  localparam int WD = $clog2(WAYS);

  if (WAYS < 2 || (WAYS & (WAYS - 1)) != 0) begin : g_chk
    $error("cfc_lru: WAYS must be a power of two");
  end

  logic [WD-1:0] age_q [WAYS];

  // Ages stay a permutation, so exactly one way is the oldest
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < WAYS; i++) begin
        age_q[i] <= WD'(i);
      end
    end else if (touch_i) begin
      for (int i = 0; i < WAYS; i++) begin
        if (WD'(i) == way_i) begin
          age_q[i] <= '0;
        end else if (age_q[i] < age_q[way_i]) begin
          age_q[i] <= age_q[i] + 1'b1;
        end
      end
    end
  end

  // Oldest way is the replacement choice
  always_comb begin
    victim_o = '0;
    for (int i = 0; i < WAYS; i++) begin
      if (age_q[i] == WD'(WAYS - 1)) begin
        victim_o = WD'(i);
      end
    end
  end
endmodule

// ### logic/cfc_pe_seq.sv
// Program/erase sequencer fed by writes to the command window
`timescale 1ns/10ps
module cfc_pe_seq
  import cfc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pe_mode_i,
  input wire logic susp_mode_i,
  input wire logic cmd_wr_i,
  input wire logic [31:0] cmd_data_i,
  input wire logic [cfc_pkg::AW-1:0] start_addr_i,
  input wire logic fl_done_i,
  input wire logic fl_susp_ok_i,
  output cfc_pkg::cfc_fl_cmd_type fl_cmd_o,
  output logic busy_o,
  output logic susp_o,
  output logic idle_o,
  output logic done_o,
  output logic viol_o
);
  cfc_pe_state_type state_q;
  logic [4:0] cnt_q;
  logic pend_q;
  logic [7:0] code;

  assign code = cmd_data_i[7:0];
  assign busy_o = (state_q == PE_RUN);
  assign susp_o = (state_q == PE_SUSP);
  assign idle_o = (state_q == PE_IDLE);

  // Command decode and operation sequencing
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= PE_IDLE;
      cnt_q <= '0;
      pend_q <= 1'b0;
      fl_cmd_o <= '0;
      done_o <= 1'b0;
      viol_o <= 1'b0;
    end else begin
      fl_cmd_o.start <= 1'b0;
      fl_cmd_o.suspend <= 1'b0;
      fl_cmd_o.resume <= 1'b0;
      fl_cmd_o.wr <= 1'b0;
      done_o <= 1'b0;
      viol_o <= 1'b0;
      case (state_q)
        PE_IDLE: begin
          if (cmd_wr_i) begin
            if (!pe_mode_i) begin
              viol_o <= 1'b1;
            end else if (code == CMD_PROGRAM) begin
              fl_cmd_o.op <= OP_PROGRAM;
              fl_cmd_o.addr <= start_addr_i & ~AW'(PGM_BYTES - 1);
              cnt_q <= '0;
              state_q <= PE_DATA;
            end else if (code == CMD_ERASE) begin
              fl_cmd_o.op <= OP_ERASE;
              fl_cmd_o.addr <= start_addr_i & ~AW'((1 << BLK_SHIFT) - 1);
              fl_cmd_o.start <= 1'b1;
              state_q <= PE_RUN;
            end else begin
              viol_o <= 1'b1;
            end
          end
        end
        PE_DATA: begin
          // Exactly one 128-byte unit is collected before start
          if (cmd_wr_i) begin
            fl_cmd_o.wr <= 1'b1;
            fl_cmd_o.wdata <= cmd_data_i;
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == 5'(PGM_WORDS - 1)) begin
              fl_cmd_o.start <= 1'b1;
              state_q <= PE_RUN;
            end
          end
        end
        PE_RUN: begin
          if (fl_done_i) begin
            done_o <= 1'b1;
            pend_q <= 1'b0;
            state_q <= PE_IDLE;
          end else if (cmd_wr_i) begin
            if (code != CMD_SUSPEND) begin
              viol_o <= 1'b1;
            end else if (fl_cmd_o.op == OP_ERASE && susp_mode_i) begin
              pend_q <= 1'b1;
            end else begin
              fl_cmd_o.suspend <= 1'b1;
              state_q <= PE_SUSP;
            end
          end else if (pend_q && fl_susp_ok_i) begin
            pend_q <= 1'b0;
            fl_cmd_o.suspend <= 1'b1;
            state_q <= PE_SUSP;
          end
        end
        PE_SUSP: begin
          if (cmd_wr_i) begin
            if (code == CMD_RESUME) begin
              fl_cmd_o.resume <= 1'b1;
              state_q <= PE_RUN;
            end else begin
              viol_o <= 1'b1;
            end
          end
        end
        default: state_q <= PE_IDLE;
      endcase
    end
  end
endmodule

// ### logic/cfc_top.sv
// Code flash read cache, register file and program/erase control
`timescale 1ns/10ps
// Functional notes
// - A 256-byte 8-way read cache with 16-byte lines fronts the flash.
// - A miss fills the lowest free way of its set, else replaces the least recently used way.
// - A cache hit is answered in one core clock cycle.
// - A miss costs one cycle up to 50 MHz, two up to 100 MHz, three above.
// - Erased bytes read as all ones.
// - Program and erase start from writes to the decoded command window.
// - Programming uses 128-byte units only; erase works on whole blocks.
// - An operation can be suspended, reads are served meanwhile, then it resumes.
// - The suspend-mode bit picks suspension (0) or erase (1) priority.
// - A prohibited access sets violation bit 7; enable bit 7 makes it interrupt.
// - P/E mode is entered by bit 0 with the key in bits 15:8; wrong keys are ignored.
// - With trusted protection on, ordinary reads of blocks 8 and 9 are blocked.
// - Software picks block 0 or block 1 as the startup area.
// - Interrupts stay live during self-programming with vectors outside flash.
// - A per-chip 16-byte identifier reads as four 32-bit words 0 to 3.
// - One control enables the read cache, another invalidates all its lines.
module cfc_top
  import cfc_pkg::*;
#(
  parameter logic [7:0] ENTRY_KEY = 8'h5A, // Arbitrary value
  parameter logic [127:0] UNIQUE_ID = 128'h0011223344556677_8899AABBCCDDEEFF // Arbitrary value
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CPU_RD_REQ_I,
  input wire logic [cfc_pkg::AW-1:0] CPU_RD_ADDR_I,
  output logic CPU_RD_READY_O,
  output logic CPU_RD_VALID_O,
  output logic [31:0] CPU_RD_DATA_O,
  output logic CPU_RD_ERR_O,
  output logic FL_RD_O,
  output logic [cfc_pkg::AW-5:0] FL_RD_ADDR_O,
  input wire logic [127:0] FL_LINE_I,
  input wire logic FL_BLANK_I,
  output cfc_pkg::cfc_fl_cmd_type FL_CMD_O,
  input wire logic FL_DONE_I,
  input wire logic FL_SUSP_OK_I,
  output logic IRQ_O
);
  import cfc_pkg::*;

  if (MISS_CYC < 1 || MISS_CYC > 3 || NLINES != 16) begin : g_chk
    $error("cfc_top: bad geometry");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic ack_q, acc, wr, cmd_wr, entry_q, susp_mode_q, cen_q, sua_q, tm_q, civ, irq_q;
  logic pe_busy, pe_susp, pe_idle, pe_done, pe_viol, rd_viol;
  logic [31:0] rdata, rd_data_q;
  logic [7:0] stat_q, ien_q, events;
  logic [AW-1:0] saddr_q, raddr_q, xa;
  cfc_rd_state_type rd_state_q;
  logic rd_ready_q, rd_valid_q, rd_err_q, fl_rd_q, alloc_q;
  logic [AW-5:0] fl_addr_q;
  logic [1:0] mcnt_q;
  logic [NLINES-1:0] vld_q;
  logic [TW-1:0] tag_q [NLINES];
  logic [127:0] line_q [NLINES];
  logic [127:0] fill_line;
  logic [BW-1:0] blk;
  logic [SIX-1:0] cset, fset, touch_set;
  logic [TW-1:0] ctag;
  logic hit, free, take, blocked, hit_go, fill_go, touch_go;
  logic [WW-1:0] vic_q, hway, fway, touch_way;
  logic [WW-1:0] lru_vic [SETS];

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request

  assign acc = WB_CYC_I && WB_STB_I && !ack_q;
  assign wr = acc && WB_WE_I;
  assign cmd_wr = wr && WB_ADR_I == OFF_CMD && WB_SEL_I == 4'hF;
  assign civ = wr && WB_ADR_I == OFF_CIV && WB_SEL_I[0] && WB_DAT_I[0];

  // Acknowledge every strobe, mapped or not
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ack_q <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      ack_q <= acc;
      if (acc && !WB_WE_I) begin
        WB_DAT_O <= rdata;
      end
    end
  end
  assign WB_ACK_O = ack_q;

  // Read mux; unmapped and write-only words read as zero
  always_comb begin
    rdata = '0;
    case (WB_ADR_I)
      OFF_STAT: rdata[7:0] = stat_q;
      OFF_IEN: rdata[7:0] = ien_q;
      OFF_ENTRY: rdata[ENTRY_BIT] = entry_q;
      OFF_SUSP: rdata[0] = susp_mode_q;
      OFF_CEN: rdata[0] = cen_q;
      OFF_SUA: rdata[0] = sua_q;
      OFF_TM: rdata[0] = tm_q;
      OFF_PST: rdata[2:0] = {entry_q, pe_susp, pe_busy};
      OFF_SADDR: rdata[AW-1:0] = saddr_q;
      OFF_UID0: rdata = UNIQUE_ID[31:0];
      OFF_UID1: rdata = UNIQUE_ID[63:32];
      OFF_UID2: rdata = UNIQUE_ID[95:64];
      OFF_UID3: rdata = UNIQUE_ID[127:96];
      default: rdata = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Plain settings; the trusted bit is set-only so code cannot drop it
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ien_q <= RST_IEN;
      susp_mode_q <= 1'b0;
      cen_q <= 1'b0;
      sua_q <= 1'b0;
      tm_q <= 1'b0;
      saddr_q <= '0;
    end else if (wr) begin
      if (WB_ADR_I == OFF_IEN && WB_SEL_I[0]) begin
        ien_q <= WB_DAT_I[7:0];
      end
      if (WB_ADR_I == OFF_SUSP && WB_SEL_I[0]) begin
        susp_mode_q <= WB_DAT_I[0];
      end
      if (WB_ADR_I == OFF_CEN && WB_SEL_I[0]) begin
        cen_q <= WB_DAT_I[0];
      end
      if (WB_ADR_I == OFF_SUA && WB_SEL_I[0]) begin
        sua_q <= WB_DAT_I[0];
      end
      if (WB_ADR_I == OFF_TM && WB_SEL_I[0]) begin
        tm_q <= tm_q | WB_DAT_I[0];
      end
      if (WB_ADR_I == OFF_SADDR && WB_SEL_I == 4'hF) begin
        saddr_q <= WB_DAT_I[AW-1:0];
      end
    end
  end

  // Mode entry needs both low lanes, the key, and an idle sequencer
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      entry_q <= 1'b0;
    end else if (wr && WB_ADR_I == OFF_ENTRY && WB_SEL_I[1:0] == 2'h3 && pe_idle &&
                 WB_DAT_I[KEY_LSB +: 8] == ENTRY_KEY) begin
      entry_q <= WB_DAT_I[ENTRY_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: write one to clear, a new event wins over the clear

  always_comb begin
    events = '0;
    events[ST_DONE_BIT] = pe_done;
    events[ST_CODE_ACCESS_VIOLATION_FLAG_BIT] = pe_viol || rd_viol;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      stat_q <= RST_STAT;
    end else if (wr && WB_ADR_I == OFF_STAT && WB_SEL_I[0]) begin
      stat_q <= (stat_q & ~WB_DAT_I[7:0]) | events;
    end else begin
      stat_q <= stat_q | events;
    end
  end

  // Level interrupt, never gated by sequencer activity
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & ien_q);
    end
  end
  assign IRQ_O = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Program/erase sequencer

  cfc_pe_seq u_seq (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .pe_mode_i(entry_q),
    .susp_mode_i(susp_mode_q),
    .cmd_wr_i(cmd_wr),
    .cmd_data_i(WB_DAT_I),
    .start_addr_i(saddr_q),
    .fl_done_i(FL_DONE_I),
    .fl_susp_ok_i(FL_SUSP_OK_I),
    .fl_cmd_o(FL_CMD_O),
    .busy_o(pe_busy),
    .susp_o(pe_susp),
    .idle_o(pe_idle),
    .done_o(pe_done),
    .viol_o(pe_viol)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path: address translation, protection and lookup

  // Startup swap exchanges blocks 0 and 1
  always_comb begin
    xa = CPU_RD_ADDR_I;
    if (sua_q && CPU_RD_ADDR_I[AW-1:BLK_SHIFT+1] == '0) begin
      xa[BLK_SHIFT] = ~CPU_RD_ADDR_I[BLK_SHIFT];
    end
  end

  assign blk = xa[AW-1:BLK_SHIFT];
  assign cset = xa[4 +: SIX];
  assign ctag = xa[AW-1 -: TW];
  assign fset = raddr_q[4 +: SIX];
  assign take = CPU_RD_REQ_I && rd_ready_q && rd_state_q == RD_IDLE;
  // A running operation owns the array; a suspended one does not
  assign blocked = (tm_q && (blk == TM_BLK_A || blk == TM_BLK_B)) || pe_busy;
  assign rd_viol = take && blocked;
  assign hit_go = take && !blocked && cen_q && hit;
  assign fill_go = rd_state_q == RD_FILL && mcnt_q == MISS_CNT;
  assign fill_line = FL_BLANK_I ? ERASED_LINE : FL_LINE_I;

  // Tag compare and first free way of the indexed set
  always_comb begin
    hit = 1'b0;
    hway = '0;
    free = 1'b0;
    fway = '0;
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (vld_q[cset*WAYS+w] && tag_q[cset*WAYS+w] == ctag) begin
        hit = 1'b1;
        hway = WW'(w);
      end
      if (!vld_q[cset*WAYS+w]) begin
        free = 1'b1;
        fway = WW'(w);
      end
    end
  end

  // Recency follows hits and completed fills
  assign touch_go = hit_go || (fill_go && alloc_q && !civ);
  assign touch_set = fill_go ? fset : cset;
  assign touch_way = fill_go ? vic_q : hway;

  for (genvar s = 0; s < SETS; s++) begin : g_lru
    cfc_lru #(.WAYS(WAYS)) u_lru (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .touch_i(touch_go && touch_set == SIX'(s)),
      .way_i(touch_way),
      .victim_o(lru_vic[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read sequencing towards the CPU and the array

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rd_state_q <= RD_IDLE;
      rd_ready_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      rd_err_q <= 1'b0;
      fl_rd_q <= 1'b0;
      fl_addr_q <= '0;
      raddr_q <= '0;
      mcnt_q <= '0;
      vic_q <= '0;
      alloc_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      rd_err_q <= 1'b0;
      case (rd_state_q)
        RD_IDLE: begin
          rd_ready_q <= 1'b1;
          if (take) begin
            if (blocked) begin
              rd_valid_q <= 1'b1;
              rd_err_q <= 1'b1;
              rd_data_q <= '0;
            end else if (cen_q && hit) begin
              rd_valid_q <= 1'b1;
              rd_data_q <= line_q[cset*WAYS+hway][xa[3:2]*32 +: 32];
            end else begin
              // Disabled cache still reads through, but never allocates
              rd_ready_q <= 1'b0;
              fl_rd_q <= 1'b1;
              fl_addr_q <= xa[AW-1:4];
              raddr_q <= xa;
              mcnt_q <= 2'h1;
              vic_q <= free ? fway : lru_vic[cset];
              alloc_q <= cen_q;
              rd_state_q <= RD_FILL;
            end
          end
        end
        RD_FILL: begin
          if (civ) begin
            alloc_q <= 1'b0; // Stale once invalidated mid-fill
          end
          if (fill_go) begin
            fl_rd_q <= 1'b0;
            rd_valid_q <= 1'b1;
            rd_data_q <= fill_line[raddr_q[3:2]*32 +: 32];
            rd_ready_q <= 1'b1;
            rd_state_q <= RD_IDLE;
          end else begin
            mcnt_q <= mcnt_q + 2'h1;
          end
        end
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

  assign CPU_RD_READY_O = rd_ready_q;
  assign CPU_RD_VALID_O = rd_valid_q;
  assign CPU_RD_DATA_O = rd_data_q;
  assign CPU_RD_ERR_O = rd_err_q;
  assign FL_RD_O = fl_rd_q;
  assign FL_RD_ADDR_O = fl_addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Cache storage

  // Invalidate and finished operations win over a fill
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      vld_q <= '0;
    end else if (civ || pe_done) begin
      vld_q <= '0;
    end else if (fill_go && alloc_q) begin
      vld_q[fset*WAYS+vic_q] <= 1'b1;
    end
  end

  // Whole line and tag land together with the valid bit
  always_ff @(posedge CLK_SYS_I) begin
    if (fill_go && alloc_q) begin
      line_q[fset*WAYS+vic_q] <= fill_line;
      tag_q[fset*WAYS+vic_q] <= raddr_q[AW-1 -: TW];
    end
  end
endmodule

// ### testbench/cfc_chk.sv
// Port-level assertions for the code flash cache and P/E control
`timescale 1ns/10ps
module cfc_chk
  import cfc_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  input wire logic CPU_RD_REQ_I,
  input wire logic [cfc_pkg::AW-1:0] CPU_RD_ADDR_I,
  input wire logic CPU_RD_READY_O,
  input wire logic CPU_RD_VALID_O,
  input wire logic [31:0] CPU_RD_DATA_O,
  input wire logic CPU_RD_ERR_O,
  input wire logic FL_RD_O,
  input wire logic [cfc_pkg::AW-5:0] FL_RD_ADDR_O,
  input wire cfc_pkg::cfc_fl_cmd_type FL_CMD_O,
  input wire logic IRQ_O
);
  logic ien7_q;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the violation enable
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ien7_q <= 1'b0;
    end else if (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_ADR_I == OFF_IEN) begin
      ien7_q <= WB_DAT_I[7];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_WB_ACK: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("late ack");
  AST_HIT_LAT: assert property (CPU_RD_REQ_I && CPU_RD_READY_O |=> CPU_RD_VALID_O || FL_RD_O)
    else $error("read not started");
  AST_MISS_LAT: assert property ($rose(FL_RD_O) |-> FL_RD_O[*2] ##1 (!FL_RD_O && CPU_RD_VALID_O))
    else $error("bad miss timing");
  AST_MISS_BUSY: assert property (FL_RD_O |-> !CPU_RD_READY_O)
    else $error("ready during fetch");
  AST_FETCH_ADR: assert property ($rose(FL_RD_O) |-> {FL_RD_ADDR_O, 4'h0} == ($past(CPU_RD_ADDR_I) & 20'hFFFF0))
    else $error("bad fetch address");
  AST_ERR_ZERO: assert property (CPU_RD_ERR_O |-> CPU_RD_VALID_O && CPU_RD_DATA_O == 32'h00000000)
    else $error("bad refused read");
  AST_ERR_IRQ: assert property (CPU_RD_ERR_O && ien7_q |-> ##[1:2] IRQ_O)
    else $error("no violation interrupt");
  AST_PE_ALIGN: assert property (FL_CMD_O.start |-> (FL_CMD_O.op == OP_ERASE ?
      FL_CMD_O.addr[14:0] == 15'h0000 : FL_CMD_O.addr[6:0] == 7'h00))
    else $error("unaligned start");
endmodule
bind cfc_top cfc_chk i_cfc_chk (.*);

// ### testbench/cfc_flash_model.sv
// Behavioural flash array answering line reads and program/erase commands
`timescale 1ns/10ps
module cfc_flash_model
  import cfc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rd_i,
  input wire logic [cfc_pkg::AW-5:0] addr_i,
  input wire cfc_pkg::cfc_fl_cmd_type cmd_i,
  output logic [127:0] line_o,
  output logic blank_o,
  output logic done_o,
  output logic susp_ok_o
);
  logic run_q;
  logic [5:0] cnt_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Word k is line address and k; idle lines show the inverse
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      line_o[32*k+:32] = {addr_i, 16'(16'h1111 * k)} ^ {32{!rd_i}};
    end
  end
  assign blank_o = rd_i && addr_i[12];
  assign susp_ok_o = run_q && cnt_q[2];
  // Operation runs 40 cycles, frozen while suspended
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || done_o) begin
      run_q <= 1'b0;
      cnt_q <= 6'h00;
    end else if (cmd_i.start || cmd_i.resume) begin
      run_q <= 1'b1;
    end else if (cmd_i.suspend) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q + 6'h01;
    end
    done_o <= rst_n_i && run_q && cnt_q == 6'h28;
  end
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the flash cache and P/E control
`timescale 1ns/10ps
module testbench;
  import cfc_pkg::*;
  localparam logic [7:0] KEY = 8'h5A; // Arbitrary value
  localparam logic [127:0] UID = 128'h0123456789ABCDEF_FEDCBA9876543210; // Arbitrary value
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000, rdat, bus_q, cpu_q, cpu_dat;
  logic [19:0] radr = 20'h00000;
  logic ack, rdy, vld, err, cerr, fl_rd, fl_blank, fl_done, fl_sok, irq;
  logic [15:0] fl_adr;
  logic [127:0] fl_line;
  cfc_fl_cmd_type fl_cmd;
  int error_cnt = 0, compares = 0, lat, n_wr = 0, n_start = 0, n_sus = 0, n_res = 0;
  always #5 clk = ~clk;
  cfc_top #(.ENTRY_KEY(KEY), .UNIQUE_ID(UID)) i_cfc_top (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat), .WB_DAT_O(bus_q), .WB_ACK_O(ack), .CPU_RD_REQ_I(req),
    .CPU_RD_ADDR_I(radr), .CPU_RD_READY_O(rdy), .CPU_RD_VALID_O(vld), .CPU_RD_DATA_O(cpu_q),
    .CPU_RD_ERR_O(err), .FL_RD_O(fl_rd), .FL_RD_ADDR_O(fl_adr), .FL_LINE_I(fl_line),
    .FL_BLANK_I(fl_blank), .FL_CMD_O(fl_cmd), .FL_DONE_I(fl_done), .FL_SUSP_OK_I(fl_sok),
    .IRQ_O(irq));
  cfc_flash_model i_cfc_flash_model (.clk_i(clk), .rst_n_i(rst_n), .rd_i(fl_rd),
    .addr_i(fl_adr), .cmd_i(fl_cmd), .line_o(fl_line), .blank_o(fl_blank),
    .done_o(fl_done), .susp_ok_o(fl_sok));
  ////////////////////////////////////////////////////////////////////////////////
  // Pulse counters, mid-cycle so a task sees them at the next rising edge
  always @(negedge clk) begin
    n_wr += fl_cmd.wr;
    n_start += fl_cmd.start;
    n_sus += fl_cmd.suspend;
    n_res += fl_cmd.resume;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic cycle: hold until ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 99);
    rdat = bus_q;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n == 99) error_cnt++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h00000000);
  endtask
  // CPU read; lat counts edges after the taking edge
  task automatic rd_cpu(input logic [19:0] a);
    req <= 1'b1;
    radr <= a;
    lat = 0;
    @(posedge clk);
    req <= 1'b0;
    do begin
      @(posedge clk);
      lat++;
    end while (vld !== 1'b1 && lat < 20);
    cpu_dat = cpu_q;
    cerr = err;
  endtask
  function automatic logic [31:0] line_word(input logic [19:0] a);
    return a[16] ? 32'hFFFFFFFF : {a[19:4], 16'(16'h1111 * a[3:2])};
  endfunction
  task automatic t_regs;
    rd(OFF_STAT);
    chk(rdat, {24'h0, RST_STAT});
    rd(OFF_IEN);
    chk(rdat, {24'h0, RST_IEN});
    for (int i = 0; i < 4; i++) begin
      wr(OFF_UID0 + 8'(4 * i), 32'h00000000);
      rd(OFF_UID0 + 8'(4 * i));
      chk(rdat, UID[32*i+:32]);
    end
    rd(8'h80);
    chk(rdat, 32'h00000000);
    $display("register test done");
  endtask
  // Fill set 0, then hit, LRU eviction and invalidate
  task automatic t_cache;
    wr(OFF_CEN, 32'h1);
    for (int i = 0; i < 8; i++) begin
      rd_cpu(20'(i * 32 + 4));
      chk(cpu_dat, line_word(20'(i * 32 + 4)));
      chk(32'(lat), 32'(1 + MISS_CYC));
    end
    rd_cpu(20'h0000C);
    chk(cpu_dat, line_word(20'h0000C));
    chk(32'(lat), 32'h1);
    rd_cpu(20'h00100);
    rd_cpu(20'h00000);
    chk(32'(lat), 32'h1);
    rd_cpu(20'h00020);
    chk(32'(lat), 32'(1 + MISS_CYC));
    wr(OFF_CIV, 32'h1);
    rd_cpu(20'h00000);
    chk(32'(lat), 32'(1 + MISS_CYC));
    rd_cpu(20'h10008);
    chk(cpu_dat, 32'hFFFFFFFF);
    $display("cache test done");
  endtask
  task automatic wait_done;
    rdat = 32'h0;
    for (int i = 0; i < 40 && rdat[0] !== 1'b1; i++) rd(OFF_STAT);
    chk(32'(rdat[0]), 32'h1);
    wr(OFF_STAT, 32'h81);
  endtask
  task automatic t_pe;
    wr(OFF_IEN, 32'h80);
    wr(OFF_SADDR, 32'h08123);
    wr(OFF_ENTRY, {16'h0, ~KEY, 8'h01});
    wr(OFF_CMD, {24'h0, CMD_ERASE});
    rd(OFF_STAT);
    chk(rdat, 32'h80);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_STAT, 32'h80);
    rd(OFF_STAT);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_ENTRY, {16'h0, KEY, 8'h01});
    rd(OFF_PST);
    chk(32'(rdat[2]), 32'h1);
    wr(OFF_CMD, {24'h0, CMD_ERASE});
    chk(32'(n_start), 32'h1);
    chk({11'h0, fl_cmd.op, fl_cmd.addr}, {11'h0, OP_ERASE, 20'h08000});
    rd_cpu(20'h00040);
    chk({31'h0, cerr}, 32'h1);
    wr(OFF_CMD, {24'h0, CMD_SUSPEND});
    rd(OFF_PST);
    chk(32'(rdat[1]) + 32'(n_sus), 32'h2);
    rd_cpu(20'h00044);
    chk({cerr, cpu_dat}, {1'b0, line_word(20'h00044)});
    wr(OFF_CMD, {24'h0, CMD_RESUME});
    chk(32'(n_res), 32'h1);
    wait_done;
    wr(OFF_CMD, {24'h0, CMD_PROGRAM});
    for (int i = 0; i < PGM_WORDS; i++) wr(OFF_CMD, 32'(i));
    chk(32'(n_wr), 32'(PGM_WORDS));
    chk({31'h0, n_start == 2}, {11'h0, fl_cmd.addr} ^ 32'h08101);
    wait_done;
    $display("program/erase test done");
  endtask
  task automatic t_tm;
    rd_cpu(20'h48000);
    chk({31'h0, cerr}, 32'h0);
    wr(OFF_TM, 32'h1);
    rd_cpu(20'h40010);
    chk({cerr, cpu_dat}, {1'b1, 32'h0});
    $display("protection test done");
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs;
    t_cache;
    t_pe;
    t_tm;
    end_of_test;
  end
  // Run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end
endmodule
